// ===== rtl/gpb_gpio_port.sv
// six-port gpio block with direction, pull-up, latch and drive level registers
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
module gpb_gpio_port import gpb_pkg::*; #(
	parameter int PW = 8,
	parameter int NPINS = 46
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [NPINS-1:0] pin_in,
	output logic [NPINS-1:0] pin_out,
	output logic [NPINS-1:0] pin_oe_n,
	output logic [NPINS-1:0] pin_pullup_on,
	input wire logic [NPINS-1:0] alt_en,
	input wire logic [NPINS-1:0] alt_out,
	input wire logic [NPINS-1:0] alt_drive,
	output logic [2*12-1:0] high_side_drive_strength,
	output logic lcd_com_en,
	output logic lcd_com_third
);
	// per-port register arrays; port 5 upper bits never hold state
	logic [PW-1:0] latch_q [GPB_NPORTS];
	logic [PW-1:0] dir_q [GPB_NPORTS];
	logic [PW-1:0] pu_q [GPB_NPORTS];
	logic [7:0] drv_a_q;
	logic [7:0] drv_b_q;
	logic [7:0] lcd_q;
	logic [NPINS-1:0] pin_sync;
	logic [NPINS-1:0] dir_flat;
	logic [NPINS-1:0] pu_flat;
	logic [NPINS-1:0] latch_flat;
	logic [2:0] sel_port;
	gpb_kind_t sel_kind;

	function automatic logic [2:0] port_of(input logic [7:0] a);
		case (a)
			GPB_OFS_P0_DATA, GPB_OFS_P0_DIR, GPB_OFS_P0_PU: port_of = 3'h0;
			GPB_OFS_P1_DATA, GPB_OFS_P1_DIR, GPB_OFS_P1_PU: port_of = 3'h1;
			GPB_OFS_P2_DATA, GPB_OFS_P2_DIR, GPB_OFS_P2_PU: port_of = 3'h2;
			GPB_OFS_P3_DATA, GPB_OFS_P3_DIR, GPB_OFS_P3_PU: port_of = 3'h3;
			GPB_OFS_P4_DATA, GPB_OFS_P4_DIR, GPB_OFS_P4_PU: port_of = 3'h4;
			GPB_OFS_P5_DATA, GPB_OFS_P5_DIR, GPB_OFS_P5_PU: port_of = 3'h5;
			default: port_of = 3'h7;
		endcase
	endfunction : port_of

	function automatic gpb_kind_t kind_of(input logic [7:0] a);
		case (a)
			GPB_OFS_P0_DATA, GPB_OFS_P1_DATA, GPB_OFS_P2_DATA,
			GPB_OFS_P3_DATA, GPB_OFS_P4_DATA, GPB_OFS_P5_DATA: kind_of = GPB_KIND_DATA;
			GPB_OFS_P0_DIR, GPB_OFS_P1_DIR, GPB_OFS_P2_DIR,
			GPB_OFS_P3_DIR, GPB_OFS_P4_DIR, GPB_OFS_P5_DIR: kind_of = GPB_KIND_DIR;
			GPB_OFS_P0_PU, GPB_OFS_P1_PU, GPB_OFS_P2_PU,
			GPB_OFS_P3_PU, GPB_OFS_P4_PU, GPB_OFS_P5_PU: kind_of = GPB_KIND_PU;
			default: kind_of = GPB_KIND_NONE;
		endcase
	endfunction : kind_of

	function automatic logic [7:0] port_mask(input int p);
		port_mask = (p == 5) ? GPB_P5_MASK : 8'hFF;
	endfunction : port_mask

	assign sel_port = port_of(reg_addr);
	assign sel_kind = kind_of(reg_addr);

	// pins arrive from outside the clock domain
	gpb_sync2 #(
		.W(NPINS)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.level_async(pin_in),
		.level_sync(pin_sync)
	);

	genvar gp;
	generate
		for (gp = 0; gp < GPB_NPORTS; gp++) begin : g_port
			localparam int BASE = gp * PW;
			localparam int NB = (gp == 5) ? 6 : PW;
			always_ff @(posedge clk) begin
				if (rst) begin
					dir_q[gp] <= GPB_RST_BYTE;
				end else if (ce && reg_wr && sel_port == 3'(gp) && sel_kind == GPB_KIND_DIR) begin
					dir_q[gp] <= reg_wdata & port_mask(gp);
				end
			end
			always_ff @(posedge clk) begin
				if (rst) begin
					pu_q[gp] <= GPB_RST_BYTE;
				end else if (ce && reg_wr && sel_port == 3'(gp) && sel_kind == GPB_KIND_PU) begin
					pu_q[gp] <= reg_wdata & port_mask(gp);
				end
			end
			always_ff @(posedge clk) begin
				if (rst) begin
					latch_q[gp] <= GPB_RST_BYTE;
				end else if (ce && reg_wr && sel_port == 3'(gp) && sel_kind == GPB_KIND_DATA) begin
					latch_q[gp] <= reg_wdata & port_mask(gp);
				end
			end
			// port 5 exposes only six pins
			assign dir_flat[BASE +: NB] = dir_q[gp][NB-1:0];
			assign pu_flat[BASE +: NB] = pu_q[gp][NB-1:0];
			assign latch_flat[BASE +: NB] = latch_q[gp][NB-1:0];
		end
	endgenerate

	// drive strength registers
	always_ff @(posedge clk) begin
		if (rst) begin
			drv_a_q <= GPB_RST_BYTE;
		end else if (ce && reg_wr && reg_addr == GPB_OFS_DRV_A) begin
			drv_a_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			drv_b_q <= GPB_RST_BYTE;
		end else if (ce && reg_wr && reg_addr == GPB_OFS_DRV_B) begin
			drv_b_q <= reg_wdata & GPB_DRV_B_MASK;
		end
	end

	// lcd common level: bit0 picks one-third over one-quarter
	always_ff @(posedge clk) begin
		if (rst) begin
			lcd_q <= GPB_RST_BYTE;
		end else if (ce && reg_wr && reg_addr == GPB_OFS_LCD_COM) begin
			lcd_q <= reg_wdata & GPB_LCD_MASK;
		end
	end

	// pin drivers; registered so outputs come straight from flops
	genvar gi;
	generate
		for (gi = 0; gi < NPINS; gi++) begin : g_pin
			always_ff @(posedge clk) begin
				if (rst) begin
					pin_out[gi] <= 1'b0;
					pin_oe_n[gi] <= 1'b1;
					pin_pullup_on[gi] <= 1'b0;
				end else if (ce) begin
					if (alt_en[gi]) begin
						pin_out[gi] <= alt_out[gi];
						pin_oe_n[gi] <= ~alt_drive[gi];
						pin_pullup_on[gi] <= ~alt_drive[gi] & pu_flat[gi];
					end else begin
						// push-pull from latch when direction set
						pin_out[gi] <= latch_flat[gi];
						pin_oe_n[gi] <= ~dir_flat[gi];
						pin_pullup_on[gi] <= ~dir_flat[gi] & pu_flat[gi];
					end
				end
			end
		end
	endgenerate

	// drive fields per nibble group, level codes passed as-is
	always_ff @(posedge clk) begin
		if (rst) begin
			high_side_drive_strength <= '0;
			lcd_com_en <= 1'b0;
			lcd_com_third <= 1'b0;
		end else if (ce) begin
			high_side_drive_strength[0 +: 2] <= drv_a_q[GPB_P0L_LSB +: GPB_FLD_W];
			high_side_drive_strength[2 +: 2] <= drv_a_q[GPB_P0H_LSB +: GPB_FLD_W];
			high_side_drive_strength[4 +: 2] <= drv_a_q[GPB_P1L_LSB +: GPB_FLD_W];
			high_side_drive_strength[6 +: 2] <= drv_a_q[GPB_P1H_LSB +: GPB_FLD_W];
			high_side_drive_strength[8 +: 2] <= drv_b_q[GPB_P2L_LSB +: GPB_FLD_W];
			high_side_drive_strength[10 +: 2] <= drv_b_q[GPB_P2H_LSB +: GPB_FLD_W];
			high_side_drive_strength[12 +: 2] <= drv_b_q[GPB_P3L_LSB +: GPB_FLD_W];
			// groups without a field stay at the strongest level
			high_side_drive_strength[23:14] <= '0;
			// lcd common drive active while any port-3 pin is alternate
			lcd_com_en <= |alt_en[31:24];
			lcd_com_third <= lcd_q[GPB_LCD_BIAS_BIT];
		end
	end

	// register read; one cycle later, unmapped reads as zero
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (ce) begin
			if (reg_rd) begin
				case (sel_kind)
					// live pin level, not the latch
					GPB_KIND_DATA: begin
						if (sel_port == 3'h5) begin
							reg_rdata <= {2'b00, pin_sync[45:40]};
						end else begin
							reg_rdata <= pin_sync[8*sel_port +: 8];
						end
					end
					GPB_KIND_DIR: reg_rdata <= dir_q[sel_port];
					GPB_KIND_PU: reg_rdata <= pu_q[sel_port];
					default: begin
						if (reg_addr == GPB_OFS_DRV_A) begin
							reg_rdata <= drv_a_q;
						end else if (reg_addr == GPB_OFS_DRV_B) begin
							reg_rdata <= drv_b_q;
						end else if (reg_addr == GPB_OFS_LCD_COM) begin
							reg_rdata <= lcd_q;
						end else begin
							reg_rdata <= '0;
						end
					end
				endcase
			end else begin
				reg_rdata <= '0;
			end
		end
	end

	// checks
	logic past_valid_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			past_valid_q <= 1'b0;
		end else begin
			past_valid_q <= 1'b1;
		end
	end

	// reset and pin mode
	dir_reset_a: assert property (@(posedge clk) $fell(rst) |-> pin_oe_n == '1)
		else $error("pins not inputs after reset");
	pu_reset_a: assert property (@(posedge clk) $fell(rst) |-> pin_pullup_on == '0)
		else $error("pull-ups on after reset");
	pu_input_a: assert property (@(posedge clk) disable iff (rst) (pin_pullup_on & ~pin_oe_n) == '0)
		else $error("pull-up on while driving");
	push_pull_a: assert property (@(posedge clk) disable iff (rst)
		ce && !alt_en[0] && dir_q[0][0] |=> !pin_oe_n[0] && pin_out[0] == $past(latch_q[0][0]))
		else $error("pin 0 not driving its latch");
	pu_on_a: assert property (@(posedge clk) disable iff (rst)
		ce && !alt_en[8] && !dir_q[1][0] && pu_q[1][0] |=> pin_pullup_on[8])
		else $error("pull-up not on for input");
	in_float_a: assert property (@(posedge clk) disable iff (rst)
		ce && !alt_en[8] && !dir_q[1][0] && !pu_q[1][0] |=> pin_oe_n[8] && !pin_pullup_on[8])
		else $error("plain input not floating");
	out_no_pu_a: assert property (@(posedge clk) disable iff (rst)
		ce && !alt_en[16] && dir_q[2][0] |=> !pin_oe_n[16] && !pin_pullup_on[16])
		else $error("pull-up on for output");

	// register writes and clock enable
	latch_wr_a: assert property (@(posedge clk) disable iff (rst)
		ce && reg_wr && reg_addr == GPB_OFS_P2_DATA |=> latch_q[2] == $past(reg_wdata))
		else $error("latch write lost");
	dir_wr_a: assert property (@(posedge clk) disable iff (rst)
		ce && reg_wr && reg_addr == GPB_OFS_P0_DIR |=> dir_q[0] == $past(reg_wdata))
		else $error("direction write lost");
	drv_a_wr_a: assert property (@(posedge clk) disable iff (rst)
		ce && reg_wr && reg_addr == GPB_OFS_DRV_A |=> drv_a_q == $past(reg_wdata))
		else $error("drive register write lost");
	hold_ce_a: assert property (@(posedge clk) disable iff (rst)
		!ce |=> $stable(latch_q[0]) && $stable(dir_q[3]) && $stable(pin_out))
		else $error("state moved with clock enable low");

	// port 5 has six pins
	p5_upper_a: assert property (@(posedge clk) disable iff (rst)
		(dir_q[5][7:6] | pu_q[5][7:6] | latch_q[5][7:6]) == 2'b00)
		else $error("port 5 upper bits hold state");
	p5_read_a: assert property (@(posedge clk) disable iff (rst)
		ce && reg_rd && reg_addr == GPB_OFS_P5_DATA |=> reg_rdata[7:6] == 2'b00)
		else $error("port 5 upper read bits set");
	p5_pin_a: assert property (@(posedge clk) disable iff (rst)
		ce && !alt_en[45] && dir_q[5][5] |=> !pin_oe_n[45] && pin_out[45] == $past(latch_q[5][5]))
		else $error("last port 5 pin not driving");

	// drive levels
	drv_b_rsv_a: assert property (@(posedge clk) disable iff (rst) drv_b_q[7:6] == 2'b00)
		else $error("reserved drive bits set");
	drv_map_a: assert property (@(posedge clk) disable iff (rst)
		ce && past_valid_q |=> high_side_drive_strength[7:6] == $past(drv_a_q[7:6]))
		else $error("drive field map wrong");
	drv_p0_a: assert property (@(posedge clk) disable iff (rst)
		ce |=> high_side_drive_strength[1:0] == $past(drv_a_q[GPB_P0L_LSB +: GPB_FLD_W]))
		else $error("port 0 low drive field wrong");
	drv_p3_a: assert property (@(posedge clk) disable iff (rst)
		ce |=> high_side_drive_strength[13:12] == $past(drv_b_q[GPB_P3L_LSB +: GPB_FLD_W]))
		else $error("port 3 low drive field wrong");
	drv_unused_a: assert property (@(posedge clk) disable iff (rst)
		high_side_drive_strength[23:14] == '0)
		else $error("unmapped drive groups not strongest");

	// alternate function and lcd common
	alt_own_a: assert property (@(posedge clk) disable iff (rst)
		ce && alt_en[3] |=> pin_out[3] == $past(alt_out[3]) && pin_oe_n[3] == !$past(alt_drive[3]))
		else $error("alternate function not overriding");
	alt_pu_a: assert property (@(posedge clk) disable iff (rst)
		ce && alt_en[0] && alt_drive[0] |=> !pin_pullup_on[0] && !pin_oe_n[0])
		else $error("alternate drive with pull-up on");
	lcd_en_a: assert property (@(posedge clk) disable iff (rst)
		ce |=> lcd_com_en == ($past(alt_en[31:24]) != 8'h00))
		else $error("lcd common enable wrong");
	lcd_level_a: assert property (@(posedge clk) disable iff (rst)
		ce |=> lcd_com_third == $past(lcd_q[GPB_LCD_BIAS_BIT]))
		else $error("lcd common level wrong");

	// read path
	rd_live_a: assert property (@(posedge clk) disable iff (rst)
		ce && reg_rd && reg_addr == GPB_OFS_P0_DATA |=> reg_rdata == $past(pin_sync[7:0]))
		else $error("data read not live pins");
	rd_idle_a: assert property (@(posedge clk) disable iff (rst) ce && !reg_rd |=> reg_rdata == '0)
		else $error("read data not cleared");
	dir_rd_a: assert property (@(posedge clk) disable iff (rst)
		ce && reg_rd && reg_addr == GPB_OFS_P3_DIR |=> reg_rdata == $past(dir_q[3]))
		else $error("direction read wrong");
	pu_rd_a: assert property (@(posedge clk) disable iff (rst)
		ce && reg_rd && reg_addr == GPB_OFS_P1_PU |=> reg_rdata == $past(pu_q[1]))
		else $error("pull-up read wrong");
endmodule : gpb_gpio_port

// ===== rtl/gpb_pkg.sv
// package of register map and field layout for the gpio port block
package gpb_pkg;
	localparam int GPB_NPORTS = 6;
	localparam logic [7:0] GPB_OFS_P0_DATA = 8'h80;
	localparam logic [7:0] GPB_OFS_P1_DATA = 8'h90;
	localparam logic [7:0] GPB_OFS_P1_DIR = 8'h91;
	localparam logic [7:0] GPB_OFS_P1_PU = 8'h92;
	localparam logic [7:0] GPB_OFS_DRV_A = 8'h96;
	localparam logic [7:0] GPB_OFS_DRV_B = 8'h97;
	localparam logic [7:0] GPB_OFS_P0_DIR = 8'h9A;
	localparam logic [7:0] GPB_OFS_P0_PU = 8'h9B;
	localparam logic [7:0] GPB_OFS_P2_DATA = 8'hA0;
	localparam logic [7:0] GPB_OFS_P2_DIR = 8'hA1;
	localparam logic [7:0] GPB_OFS_P2_PU = 8'hA2;
	localparam logic [7:0] GPB_OFS_P3_DATA = 8'hB0;
	localparam logic [7:0] GPB_OFS_P3_DIR = 8'hB1;
	localparam logic [7:0] GPB_OFS_P3_PU = 8'hB2;
	localparam logic [7:0] GPB_OFS_P4_DATA = 8'hC0;
	localparam logic [7:0] GPB_OFS_P4_DIR = 8'hC1;
	localparam logic [7:0] GPB_OFS_P4_PU = 8'hC2;
	localparam logic [7:0] GPB_OFS_P5_DATA = 8'hD8;
	localparam logic [7:0] GPB_OFS_P5_DIR = 8'hD9;
	localparam logic [7:0] GPB_OFS_P5_PU = 8'hDA;
	// own choice: lcd common level select for port 3
	localparam logic [7:0] GPB_OFS_LCD_COM = 8'hDB;
	localparam logic [7:0] GPB_RST_BYTE = 8'h00;
	localparam logic [7:0] GPB_P5_MASK = 8'h3F;
	localparam logic [7:0] GPB_DRV_B_MASK = 8'h3F;
	localparam logic [7:0] GPB_LCD_MASK = 8'h01;
	localparam int GPB_LCD_BIAS_BIT = 0;
	localparam int GPB_FLD_W = 2;
	localparam int GPB_P0L_LSB = 0;
	localparam int GPB_P0H_LSB = 2;
	localparam int GPB_P1L_LSB = 4;
	localparam int GPB_P1H_LSB = 6;
	localparam int GPB_P2L_LSB = 0;
	localparam int GPB_P2H_LSB = 2;
	localparam int GPB_P3L_LSB = 4;
	typedef enum logic [1:0] {
		GPB_KIND_DATA = 2'b00,
		GPB_KIND_DIR = 2'b01,
		GPB_KIND_PU = 2'b10,
		GPB_KIND_NONE = 2'b11
	} gpb_kind_t;
endpackage : gpb_pkg

// ===== rtl/gpb_sync2.sv
// two-flop synchroniser for pin levels
`timescale 1ns/1ns
module gpb_sync2 #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [W-1:0] level_async,
	output logic [W-1:0] level_sync
);
	logic [W-1:0] meta_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= '0;
			level_sync <= '0;
		end else if (ce) begin
			meta_q <= level_async;
			level_sync <= meta_q;
		end
	end
endmodule : gpb_sync2

// ===== bench/gpb_pin_model.sv
// pin level model: device drive, outside drive, pull-up and floating pins
`timescale 1ns/1ns
module gpb_pin_model #(
	parameter int NPINS = 46
) (
	input wire logic clk,
	input wire logic [NPINS-1:0] pin_out,
	input wire logic [NPINS-1:0] pin_oe_n,
	input wire logic [NPINS-1:0] pin_pullup_on,
	input wire logic [NPINS-1:0] ext_en,
	input wire logic [NPINS-1:0] ext_val,
	output logic [NPINS-1:0] pin_level
);
	logic [NPINS-1:0] float_q = '0;
	// a floating pin wanders so a stale level never looks valid
	always_ff @(posedge clk) begin
		float_q <= ~float_q;
	end
	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			if (!pin_oe_n[i])
				pin_level[i] = pin_out[i];
			else if (ext_en[i])
				pin_level[i] = ext_val[i];
			else if (pin_pullup_on[i])
				pin_level[i] = 1'b1;
			else
				pin_level[i] = float_q[i];
		end
	end
endmodule : gpb_pin_model

// ===== bench/gpb_gpio_port_tb.sv
// self-checking bench for the gpio port block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin err_count++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end
module gpb_gpio_port_tb import gpb_pkg::*;;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} gpb_row_t;
	logic clk, rst, ce, reg_wr, reg_rd, lcd_com_en, lcd_com_third;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [45:0] pin_level, pin_out, pin_oe_n, pin_pullup_on, alt_en, alt_out, alt_drive, ext_en, ext_val;
	logic [23:0] hsd;
	int err_count = 0;
	int checks_done = 0;
	gpb_row_t rows [8] = '{'{GPB_OFS_P4_DIR, 8'hA5, 8'hA5}, '{GPB_OFS_P4_PU, 8'h5A, 8'h5A},
		'{GPB_OFS_P5_DIR, 8'hFF, 8'h3F}, '{GPB_OFS_P5_PU, 8'hFF, 8'h3F}, '{GPB_OFS_DRV_A, 8'hC6, 8'hC6},
		'{GPB_OFS_DRV_B, 8'hFF, 8'h3F}, '{8'h55, 8'hFF, 8'h00}, '{GPB_OFS_LCD_COM, 8'hFF, 8'h01}};
	gpb_gpio_port DUT (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_level), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .pin_pullup_on(pin_pullup_on), .alt_en(alt_en), .alt_out(alt_out),
		.alt_drive(alt_drive), .high_side_drive_strength(hsd), .lcd_com_en(lcd_com_en),
		.lcd_com_third(lcd_com_third));
	gpb_pin_model pins (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup_on(pin_pullup_on),
		.ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_level));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		`CHK("reg_rdata", e, reg_rdata)
	endtask : rd
	// register change to pin, then two sync flops
	task automatic settle();
		repeat (5) @(posedge clk);
		#1;
	endtask : settle
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	initial begin
		#100000;
		err_count++;
		wrap_up();
	end
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		alt_en = '0;
		alt_out = '0;
		alt_drive = '0;
		ext_en = '1;
		ext_val = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		// everything starts as a plain input
		`CHK("pin_oe_n", 46'h3FFF_FFFF_FFFF, pin_oe_n)
		`CHK("pin_pullup_on", 46'h0, pin_pullup_on)
		`CHK("drive", 24'h0, hsd)
		foreach (rows[i]) rd(rows[i].a, 8'h00);
		// register rows: write then read back through the masks
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		settle();
		`CHK("drive", 24'h003FC6, hsd)
		`CHK("lcd_third", 1'b1, lcd_com_third)
		// port 0 drives its latch, read back from the pins
		ext_en[7:0] <= 8'h00;
		wr(GPB_OFS_P0_DATA, 8'h5A);
		wr(GPB_OFS_P0_DIR, 8'hFF);
		settle();
		`CHK("p0_oe_n", 8'h00, pin_oe_n[7:0])
		`CHK("p0_out", 8'h5A, pin_out[7:0])
		rd(GPB_OFS_P0_DATA, 8'h5A);
		// port 1 stays input and reads the outside level
		ext_val[15:8] <= 8'hC3;
		wr(GPB_OFS_P1_PU, 8'h01);
		settle();
		`CHK("p1_pullup", 8'h01, pin_pullup_on[15:8])
		rd(GPB_OFS_P1_PU, 8'h01);
		rd(GPB_OFS_P1_DATA, 8'hC3);
		// port 2 pull-ups only on its input half
		ext_en[23:16] <= 8'h00;
		wr(GPB_OFS_P2_PU, 8'hFF);
		wr(GPB_OFS_P2_DIR, 8'h0F);
		wr(GPB_OFS_P2_DATA, 8'h05);
		settle();
		`CHK("p2_pullup", 8'hF0, pin_pullup_on[23:16])
		`CHK("p2_out", 4'h5, pin_out[19:16])
		rd(GPB_OFS_P2_DATA, 8'hF5);
		// port 5 has six pins only
		wr(GPB_OFS_P5_DATA, 8'hFF);
		// unused port 4 parked as push-pull outputs
		wr(GPB_OFS_P4_DIR, 8'hFF);
		settle();
		`CHK("p5_out", 6'h3F, pin_out[45:40])
		`CHK("p4_oe_n", 8'h00, pin_oe_n[39:32])
		rd(GPB_OFS_P5_DATA, 8'h3F);
		// alternate function takes pins 0 and 3 and a port 3 pin
		alt_en[0] <= 1'b1;
		alt_out[0] <= 1'b1;
		alt_drive[0] <= 1'b1;
		alt_en[24] <= 1'b1;
		alt_en[3] <= 1'b1;
		settle();
		`CHK("alt_pin", 1'b1, pin_out[0])
		`CHK("alt_oe_n", 1'b0, pin_oe_n[0])
		`CHK("alt_pullup", 1'b0, pin_pullup_on[0])
		`CHK("alt_in_oe_n", 1'b1, pin_oe_n[3])
		`CHK("lcd_en", 1'b1, lcd_com_en)
		// second reset in mid-run
		alt_en <= '0;
		alt_drive <= '0;
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK("pin_oe_n", 46'h3FFF_FFFF_FFFF, pin_oe_n)
		`CHK("pin_pullup_on", 46'h0, pin_pullup_on)
		`CHK("drive", 24'h0, hsd)
		rd(GPB_OFS_P2_DIR, 8'h00);
		// clock enable low: the write must not land
		ce <= 1'b0;
		wr(GPB_OFS_P3_DIR, 8'hFF);
		ce <= 1'b1;
		rd(GPB_OFS_P3_DIR, 8'h00);
		wrap_up();
	end
endmodule : gpb_gpio_port_tb
